// *** logic/digipot_pkg.sv ***
package digipot_pkg;
    // timing of the reference clock
    localparam int CLK_MHZ = 250;
    // longest nonvolatile store time, in ms
    localparam int NV_WRITE_MS = 10;
    localparam int NV_WRITE_CYCLES = NV_WRITE_MS * CLK_MHZ * 1000;
    // wiper settle delay, in ns (value of our own)
    localparam int WIPER_DELAY_NS = 1000;
    localparam int WIPER_DELAY_CYCLES = WIPER_DELAY_NS * CLK_MHZ / 1000;
    // instruction opcodes, upper nibble of the instruction byte
    localparam logic [3:0] OP_RD_WIPER = 4'h9;
    localparam logic [3:0] OP_WR_WIPER = 4'hA;
    localparam logic [3:0] OP_RD_STORE = 4'hB;
    localparam logic [3:0] OP_WR_STORE = 4'hC;
    localparam logic [3:0] OP_STORE_TO_WIPER = 4'hD;
    localparam logic [3:0] OP_WIPER_TO_STORE = 4'hE;
    localparam logic [3:0] OP_STEP = 4'h2;
    // bit count that marks the acknowledge slot
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;
    // store contents after reset, wiper limits
    localparam logic [7:0] STORE_INIT = 8'h00;
    localparam logic [7:0] WIPER_MAX = 8'hFF;
    localparam logic [7:0] WIPER_MIN = 8'h00;
    localparam int NUM_STORES = 16;
    // link phases
    typedef enum logic [2:0] {
        PH_IDLE, PH_ID, PH_INSTR, PH_DATA_IN, PH_DATA_OUT, PH_STEP, PH_IGNORE
    } phase_t;
    // command handed from the link to the core
    typedef struct packed {
        logic [3:0] op;
        logic [1:0] bankSel;
        logic [1:0] regSel;
        logic [7:0] data;
    } cmd_t;
endpackage

// *** logic/digipot_register_command_unit.sv ***
`timescale 1ns/1ps
module digipot_register_command_unit
    import digipot_pkg::*;
#(
    parameter logic [3:0] TypeCode = 4'hA, // arbitrary type code
    parameter int NvWriteCycles = NV_WRITE_CYCLES,
    parameter int WiperDelayCycles = WIPER_DELAY_CYCLES
) (
    // reference clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // two-wire link, open drain data
    input wire logic sclk,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // address straps
    input wire logic [2:0] slaveAddress,
    // wiper tap and store status
    output logic [7:0] wiperTap,
    output logic nvBusy
);
    // link domain state
    phase_t phase_r;
    logic [3:0] bitCnt_r;
    logic [7:0] shift_r; // received bits
    logic [7:0] tx_r; // byte being shifted out
    logic sdaAtRise_r; // data seen at last rise
    logic accept_r; // last byte was acked
    logic sdaOe_r;
    logic sdaOut_r;
    cmd_t cmd_r; // held until the next command
    logic cmdTgl_r, upTgl_r, downTgl_r;
    logic startTgl_r, startAck_r;
    logic [2:0] addrS1_r, addrS2_r;
    logic busyS1_r, busyS2_r;
    logic [7:0] nextByte;
    logic accept;
    logic startSeen;
    // core domain state
    logic [7:0] store_r [NUM_STORES];
    logic [7:0] wiper_r;
    logic [7:0] wiperTap_r;
    logic [31:0] tapCnt_r;
    logic busy_r;
    logic [31:0] nvCnt_r;
    logic [3:0] nvIdx_r;
    logic [7:0] nvData_r;
    logic bootPending_r;
    logic [2:0] cmdS_r, upS_r, downS_r; // stage 3 is the edge memory
    logic sclS1_r, sclS2_r, sdaS1_r, sdaS2_r, sdaPrev_r;
    logic stopped_r, pending_r;
    cmd_t cmdHeld_r;
    logic cmdEdge, upEdge, downEdge, stopDet, startDet, execNow;
    logic [7:0] bank0Pick;

    // start marker: SDA falls while SCL is high
    always_ff @(negedge sdaIn or posedge rst)
    begin
        if (rst)
            startTgl_r <= 1'b0;
        else if (sclk)
            startTgl_r <= ~startTgl_r;
    end

    // data is taken at the rising edge of the link clock
    always_ff @(posedge sclk or posedge rst)
    begin
        if (rst)
            sdaAtRise_r <= 1'b0;
        else
            sdaAtRise_r <= sdaIn;
    end

    // straps and busy enter the link domain through two flops
    always_ff @(negedge sclk or posedge rst)
    begin
        if (rst)
        begin
            addrS1_r <= 3'h0;
            addrS2_r <= 3'h0;
            busyS1_r <= 1'b0;
            busyS2_r <= 1'b0;
        end
        else
        begin
            addrS1_r <= slaveAddress;
            addrS2_r <= addrS1_r;
            busyS1_r <= busy_r;
            busyS2_r <= busyS1_r;
        end
    end

    assign startSeen = startTgl_r != startAck_r;
    assign nextByte = {shift_r[6:0], sdaAtRise_r};

    // acknowledge decision on the byte that completes at this fall
    always_comb
    begin
        accept = 1'b0;
        unique case (phase_r)
            PH_ID:
                accept = nextByte[7:4] == TypeCode && !nextByte[3]
                    && nextByte[2:0] == addrS2_r && !busyS2_r;
            PH_INSTR:
                unique case (nextByte[7:4])
                    OP_RD_STORE, OP_WR_STORE: accept = 1'b1;
                    OP_STORE_TO_WIPER, OP_WIPER_TO_STORE:
                        accept = nextByte[1:0] == 2'b00;
                    OP_RD_WIPER, OP_WR_WIPER, OP_STEP:
                        accept = nextByte[3:0] == 4'h0;
                    default: accept = 1'b0;
                endcase
            PH_DATA_IN: accept = 1'b1;
            default: accept = 1'b0;
        endcase
    end

    // link engine: every change lands on a falling clock edge
    always_ff @(negedge sclk or posedge rst)
    begin
        if (rst)
        begin
            phase_r <= PH_IDLE;
            bitCnt_r <= 4'h0;
            shift_r <= 8'h00;
            tx_r <= 8'h00;
            accept_r <= 1'b0;
            sdaOe_r <= 1'b0;
            sdaOut_r <= 1'b0;
            cmd_r <= '0;
            cmdTgl_r <= 1'b0;
            upTgl_r <= 1'b0;
            downTgl_r <= 1'b0;
            startAck_r <= 1'b0;
        end
        else if (startSeen)
        begin
            // a start always wins, also a repeated one
            startAck_r <= startTgl_r;
            phase_r <= PH_ID;
            bitCnt_r <= 4'h0;
            sdaOe_r <= 1'b0;
        end
        else if (phase_r == PH_STEP)
        begin
            // a stop pulse never falls, so it never steps
            if (sdaAtRise_r)
                upTgl_r <= ~upTgl_r;
            else
                downTgl_r <= ~downTgl_r;
        end
        else if (phase_r == PH_DATA_OUT)
        begin
            if (bitCnt_r == ACK_SLOT)
                phase_r <= PH_IGNORE; // master ack, then stop
            else
            begin
                bitCnt_r <= bitCnt_r + 4'h1;
                tx_r <= {tx_r[6:0], 1'b0};
                // release for the master ack after bit 0
                sdaOe_r <= bitCnt_r != LAST_BIT && !tx_r[6];
            end
        end
        else if (phase_r != PH_IDLE && phase_r != PH_IGNORE)
        begin
            if (bitCnt_r != ACK_SLOT)
            begin
                shift_r <= nextByte;
                bitCnt_r <= bitCnt_r + 4'h1;
                if (bitCnt_r == LAST_BIT)
                begin
                    sdaOe_r <= accept;
                    accept_r <= accept;
                end
            end
            else
            begin
                // end of the acknowledge slot
                bitCnt_r <= 4'h0;
                sdaOe_r <= 1'b0;
                phase_r <= PH_IGNORE;
                if (accept_r)
                begin
                    unique case (phase_r)
                        PH_ID: phase_r <= PH_INSTR;
                        PH_INSTR:
                        begin
                            // the byte puts register bits above bank bits, the struct the reverse
                            cmd_r <= {shift_r[7:4], shift_r[1:0], shift_r[3:2], 8'h00};
                            unique case (shift_r[7:4])
                                OP_RD_WIPER:
                                begin
                                    // core word read here without a handshake: loads wait for
                                    // a stop and store writes refuse new frames, so it is still
                                    tx_r <= wiper_r;
                                    sdaOe_r <= !wiper_r[7];
                                    phase_r <= PH_DATA_OUT;
                                end
                                OP_RD_STORE:
                                begin
                                    tx_r <= store_r[{shift_r[1:0], shift_r[3:2]}];
                                    sdaOe_r <= !store_r[{shift_r[1:0], shift_r[3:2]}][7];
                                    phase_r <= PH_DATA_OUT;
                                end
                                OP_WR_WIPER, OP_WR_STORE: phase_r <= PH_DATA_IN;
                                OP_STEP: phase_r <= PH_STEP;
                                default: cmdTgl_r <= ~cmdTgl_r;
                            endcase
                        end
                        default:
                        begin
                            // data byte of a write
                            cmd_r.data <= shift_r;
                            cmdTgl_r <= ~cmdTgl_r;
                        end
                    endcase
                end
            end
        end
    end

    assign sdaOe = sdaOe_r;
    assign sdaOut = sdaOut_r;

    // link events into the core domain, two flops then an edge
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            cmdS_r <= 3'h0;
            upS_r <= 3'h0;
            downS_r <= 3'h0;
            {sclS1_r, sclS2_r, sdaS1_r, sdaS2_r, sdaPrev_r} <= 5'h1F;
        end
        else
        begin
            cmdS_r <= {cmdS_r[1:0], cmdTgl_r};
            upS_r <= {upS_r[1:0], upTgl_r};
            downS_r <= {downS_r[1:0], downTgl_r};
            {sclS1_r, sclS2_r} <= {sclk, sclS1_r};
            {sdaS1_r, sdaS2_r, sdaPrev_r} <= {sdaIn, sdaS1_r, sdaS2_r};
        end
    end

    assign cmdEdge = cmdS_r[2] != cmdS_r[1];
    assign upEdge = upS_r[2] != upS_r[1];
    assign downEdge = downS_r[2] != downS_r[1];
    assign stopDet = sclS2_r && sdaS2_r && !sdaPrev_r;
    assign startDet = sclS2_r && !sdaS2_r && sdaPrev_r;
    assign execNow = pending_r && stopped_r;
    assign bank0Pick = store_r[{2'b00, cmdHeld_r.regSel}];

    // commands wait for the stop; cmd_r is still by the time the edge shows
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            pending_r <= 1'b0;
            stopped_r <= 1'b1;
            cmdHeld_r <= '0;
        end
        else
        begin
            if (stopDet)
                stopped_r <= 1'b1;
            else if (startDet)
                stopped_r <= 1'b0;
            if (cmdEdge)
            begin
                // arrival beats execution in the same cycle
                cmdHeld_r <= cmd_r;
                pending_r <= 1'b1;
            end
            else if (execNow)
                pending_r <= 1'b0;
        end
    end

    // wiper counter: boot recall, direct loads, then steps
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            wiper_r <= WIPER_MIN;
            bootPending_r <= 1'b1;
        end
        else if (bootPending_r)
        begin
            wiper_r <= store_r[0];
            bootPending_r <= 1'b0;
        end
        else if (execNow && cmdHeld_r.op == OP_WR_WIPER && !cmdEdge)
            wiper_r <= cmdHeld_r.data;
        else if (execNow && cmdHeld_r.op == OP_STORE_TO_WIPER && !cmdEdge)
            wiper_r <= bank0Pick;
        else if (upEdge && !downEdge && wiper_r != WIPER_MAX)
            wiper_r <= wiper_r + 8'h01;
        else if (downEdge && !upEdge && wiper_r != WIPER_MIN)
            wiper_r <= wiper_r - 8'h01;
    end

    // nonvolatile write cycle; data lands at the end of it
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            busy_r <= 1'b0;
            nvCnt_r <= 32'h0;
            nvIdx_r <= 4'h0;
            nvData_r <= 8'h00;
            for (int i = 0; i < NUM_STORES; i++)
                store_r[i] <= STORE_INIT;
        end
        else if (busy_r)
        begin
            nvCnt_r <= nvCnt_r + 32'h1;
            if (nvCnt_r == 32'(NvWriteCycles - 1))
            begin
                store_r[nvIdx_r] <= nvData_r;
                busy_r <= 1'b0;
            end
        end
        else if (execNow && !cmdEdge && cmdHeld_r.op == OP_WR_STORE)
        begin
            busy_r <= 1'b1;
            nvCnt_r <= 32'h0;
            nvIdx_r <= {cmdHeld_r.bankSel, cmdHeld_r.regSel};
            nvData_r <= cmdHeld_r.data;
        end
        else if (execNow && !cmdEdge && cmdHeld_r.op == OP_WIPER_TO_STORE)
        begin
            busy_r <= 1'b1;
            nvCnt_r <= 32'h0;
            nvIdx_r <= {2'b00, cmdHeld_r.regSel};
            nvData_r <= wiper_r;
        end
    end

    // tap follows the counter only after the response delay
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            wiperTap_r <= WIPER_MIN;
            tapCnt_r <= 32'h0;
        end
        else if (wiper_r == wiperTap_r)
            tapCnt_r <= 32'h0;
        else if (tapCnt_r == 32'(WiperDelayCycles - 1))
        begin
            wiperTap_r <= wiper_r;
            tapCnt_r <= 32'h0;
        end
        else
            tapCnt_r <= tapCnt_r + 32'h1;
    end

    assign wiperTap = wiperTap_r;
    assign nvBusy = busy_r;

    a_nv_bound: assert property (@(posedge ref_clk) disable iff (rst)
        busy_r |-> nvCnt_r < 32'(NvWriteCycles)) else $error("store write too long");
    a_nv_commit: assert property (@(posedge ref_clk) disable iff (rst)
        busy_r && nvCnt_r == 32'(NvWriteCycles - 1) |=> !busy_r && store_r[nvIdx_r] == nvData_r)
        else $error("store not committed");
    a_copy_bank0: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(busy_r) && cmdHeld_r.op == OP_WIPER_TO_STORE |-> nvIdx_r[3:2] == 2'b00
            && nvData_r == $past(wiper_r)) else $error("copy to wrong store");
    a_load_wiper: assert property (@(posedge ref_clk) disable iff (rst)
        execNow && !cmdEdge && !bootPending_r && cmdHeld_r.op == OP_STORE_TO_WIPER
            |=> wiper_r == $past(bank0Pick)) else $error("copy to wiper wrong");
    a_write_wiper: assert property (@(posedge ref_clk) disable iff (rst)
        execNow && !cmdEdge && !bootPending_r && cmdHeld_r.op == OP_WR_WIPER
            |=> wiper_r == $past(cmdHeld_r.data)) else $error("wiper write lost");
    a_step_sat: assert property (@(posedge ref_clk) disable iff (rst)
        wiper_r == WIPER_MAX && upEdge && !execNow |=> wiper_r == WIPER_MAX)
        else $error("wiper wrapped");
    a_step_down: assert property (@(posedge ref_clk) disable iff (rst)
        downEdge && !upEdge && !execNow && !bootPending_r && wiper_r != WIPER_MIN
            |=> wiper_r == $past(wiper_r) - 8'h01) else $error("down step wrong");
    a_boot_recall: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(bootPending_r) |-> wiper_r == store_r[0]) else $error("no recall");
    a_tap_delay: assert property (@(posedge ref_clk) disable iff (rst)
        $changed(wiperTap_r) |-> $past(tapCnt_r) == 32'(WiperDelayCycles - 1))
        else $error("tap moved early");
    a_id_refuse: assert property (@(negedge sclk) disable iff (rst)
        phase_r == PH_ID && bitCnt_r == LAST_BIT && !startSeen && busyS2_r |=> !sdaOe_r)
        else $error("ack while busy");
    c_store_write: cover property (@(posedge ref_clk) $rose(busy_r));
    c_step_up: cover property (@(posedge ref_clk) upEdge);
    c_read_out: cover property (@(negedge sclk) phase_r == PH_DATA_OUT);
endmodule

// *** testbench/twowire_host.sv ***
`timescale 1ns/1ps
// two-wire bus master, makes the link clock only within frames
module twowire_host (
    // link clock, idles high
    output logic sclk,
    // high while the master pulls data low
    output logic sdaLow,
    // resolved data level
    input wire logic sdaIn
);
    localparam int HalfNs = 6;
    // both lines released to the pull-up
    initial
    begin
        sclk = 1'b1;
        sdaLow = 1'b0;
    end
    // start, also a repeated start
    task automatic start();
        sdaLow = 1'b0;
        #HalfNs sclk = 1'b1;
        #HalfNs sdaLow = 1'b1;
        #HalfNs sclk = 1'b0;
    endtask
    // stop: data rises while clock high
    task automatic stop();
        sdaLow = 1'b1;
        #HalfNs sclk = 1'b1;
        #HalfNs sdaLow = 1'b0;
        #HalfNs;
    endtask
    // data moves only while clock is low, sampled mid-high
    task automatic bit_clk(input logic b, output logic s);
        sdaLow = ~b;
        #HalfNs sclk = 1'b1;
        #(HalfNs / 2) s = sdaIn;
        #(HalfNs / 2) sclk = 1'b0;
    endtask
    // msb first, ninth clock reads the device ack
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_clk(b[i], s);
        bit_clk(1'b1, s);
        ack = ~s;
    endtask
    // msb first, then master ack
    task automatic rd_byte(output logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_clk(1'b1, v[i]);
        bit_clk(1'b0, s);
    endtask
endmodule

// *** testbench/digipot_register_command_unit_tb.sv ***
`timescale 1ns/1ps
module digipot_register_command_unit_tb;
    import digipot_pkg::*;
    localparam logic [3:0] TYPE_CODE = 4'h6; // arbitrary type code
    localparam int NV_CYC = 200; // long enough to refuse one id byte
    localparam int TAP_DLY = 4;
    typedef struct packed {
        logic isVal;
        logic [7:0] val;
    } note_t;
    logic ref_clk, rst, sclk, hostLow, sdaIn, sdaOut, sdaOe, nvBusy;
    logic [2:0] slaveAddress;
    logic [7:0] wiperTap;
    note_t expQ[$]; // expected results, oldest first
    note_t res, head;
    event resEv;
    int error_cnt = 0;
    int checks_done = 0;
    logic [7:0] shadow [NUM_STORES]; // expected store contents
    logic [7:0] wip; // expected wiper
    logic [7:0] badIns [4] = '{8'h91, 8'hD1, 8'hE2, 8'h30};
    // open drain wire with pull-up
    assign sdaIn = ~(hostLow | (sdaOe & ~sdaOut));

    digipot_register_command_unit #(
        .TypeCode(TYPE_CODE),
        .NvWriteCycles(NV_CYC),
        .WiperDelayCycles(TAP_DLY)
    ) i_dut (
        .ref_clk(ref_clk),
        .rst(rst),
        .sclk(sclk),
        .sdaIn(sdaIn),
        .sdaOut(sdaOut),
        .sdaOe(sdaOe),
        .slaveAddress(slaveAddress),
        .wiperTap(wiperTap),
        .nvBusy(nvBusy)
    );
    twowire_host i_host (
        .sclk(sclk),
        .sdaLow(hostLow),
        .sdaIn(sdaIn)
    );

    // core clock
    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic bad(input string m);
        error_cnt++;
        $display("BAD %0t %s", $time, m);
    endtask
    task automatic cmp_ack(input logic e, input logic g);
        checks_done++;
        if (g !== e)
            bad($sformatf("ack %b want %b", g, e));
    endtask
    task automatic cmp_val(input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e)
            bad($sformatf("value %h want %h", g, e));
    endtask
    // note the expectation, then publish the result
    task automatic post(input logic isVal, input logic [7:0] e, input logic [7:0] g);
        expQ.push_back({isVal, e});
        res = {isVal, g};
        ->resEv;
        #1;
    endtask
    // watcher: oldest note against each result
    initial
    begin
        forever
        begin
            @(resEv);
            if (expQ.size() == 0)
                bad("result without note");
            else
            begin
                head = expQ.pop_front();
                if (head.isVal !== res.isVal)
                    bad("result kind");
                else if (res.isVal)
                    cmp_val(head.val, res.val);
                else
                    cmp_ack(head.val[0], res.val[0]);
            end
        end
    end

    task automatic send(input logic [7:0] b, input logic e);
        logic a;
        i_host.wr_byte(b, a);
        post(1'b0, {7'h0, e}, {7'h0, a});
    endtask
    // n: 2 two-byte, 3 write, 4 read expecting e
    task automatic cmd(input logic [7:0] ins, input logic [7:0] d, input int n,
        input logic [7:0] e);
        logic [7:0] g;
        i_host.start();
        send({TYPE_CODE, 1'b0, slaveAddress}, 1'b1);
        send(ins, 1'b1);
        if (n == 3)
            send(d, 1'b1);
        if (n == 4)
        begin
            i_host.rd_byte(g);
            post(1'b1, e, g);
        end
        i_host.stop();
        repeat (10) @(posedge ref_clk);
    endtask
    // tap settles after the response delay
    task automatic tap();
        repeat (TAP_DLY) @(posedge ref_clk);
        // look after the edge, once the tap has settled
        #1;
        post(1'b1, wip, wiperTap);
    endtask
    // count busy cycles, bounded
    task automatic wait_nv(input int lo);
        int c;
        logic seen;
        c = 0;
        seen = nvBusy;
        while (nvBusy !== 1'b0 && c < NV_CYC + 50)
        begin
            @(posedge ref_clk);
            c++;
        end
        post(1'b0, 8'h01, {7'h0, seen});
        post(1'b0, 8'h01, {7'h0, c <= NV_CYC && c >= lo});
    endtask
    // load, step n times, check saturation
    task automatic steps(input logic [7:0] st, input int n, input logic up);
        logic s;
        wip = st;
        cmd({OP_WR_WIPER, 4'h0}, st, 3, 8'h00);
        i_host.start();
        send({TYPE_CODE, 1'b0, slaveAddress}, 1'b1);
        send({OP_STEP, 4'h0}, 1'b1);
        for (int k = 0; k < n; k++)
        begin
            i_host.bit_clk(up, s);
            if (up && wip != WIPER_MAX)
                wip = wip + 8'h01;
            else if (!up && wip != WIPER_MIN)
                wip = wip - 8'h01;
        end
        i_host.stop();
        repeat (10) @(posedge ref_clk);
        tap();
        cmd({OP_RD_WIPER, 4'h0}, 8'h00, 4, wip);
    endtask

    task automatic finish_test();
        if (error_cnt == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // watchdog, far beyond the expected run
    initial
    begin
        repeat (60000) @(posedge ref_clk);
        bad("timeout");
        finish_test();
    end

    // main sequence
    initial
    begin
        rst = 1'b0;
        slaveAddress = 3'h0;
        void'($urandom(69264));
        // raise reset off the edge so the link flops see a clean rising edge
        #1 rst = 1'b1;
        @(posedge ref_clk);
        slaveAddress <= 3'($urandom);
        repeat (7) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (10) @(posedge ref_clk);
        wip = STORE_INIT;
        tap();
        cmd({OP_RD_WIPER, 4'h0}, 8'h00, 4, wip);
        // every store of every bank, busy refusal on the first
        for (int i = 0; i < NUM_STORES; i++)
        begin
            shadow[i] = 8'($urandom);
            cmd({OP_WR_STORE, i[1:0], i[3:2]}, shadow[i], 3, 8'h00);
            if (i == 0)
            begin
                i_host.start();
                send({TYPE_CODE, 1'b0, slaveAddress}, 1'b0);
                i_host.stop();
            end
            wait_nv(i == 0 ? 0 : NV_CYC - 20);
        end
        for (int i = 0; i < NUM_STORES; i++)
            cmd({OP_RD_STORE, i[1:0], i[3:2]}, 8'h00, 4, shadow[i]);
        wip = 8'($urandom);
        cmd({OP_WR_WIPER, 4'h0}, wip, 3, 8'h00);
        tap();
        cmd({OP_RD_WIPER, 4'h0}, 8'h00, 4, wip);
        // bank-0 stores into the wiper
        for (int r = 0; r < 4; r++)
        begin
            wip = shadow[r];
            cmd({OP_STORE_TO_WIPER, r[1:0], 2'b00}, 8'h00, 2, 8'h00);
            tap();
            cmd({OP_RD_WIPER, 4'h0}, 8'h00, 4, wip);
        end
        // wiper into bank-0 store 3, bank 1 untouched
        wip = 8'($urandom);
        cmd({OP_WR_WIPER, 4'h0}, wip, 3, 8'h00);
        cmd({OP_WIPER_TO_STORE, 2'b11, 2'b00}, 8'h00, 2, 8'h00);
        wait_nv(NV_CYC - 20);
        shadow[3] = wip;
        cmd({OP_RD_STORE, 4'hC}, 8'h00, 4, shadow[3]);
        cmd({OP_RD_STORE, 4'hD}, 8'h00, 4, shadow[7]);
        steps(8'hFD, 4, 1'b1);
        steps(8'h02, 4, 1'b0);
        steps(8'($urandom), 3, 1'($urandom));
        // refused id and instruction bytes
        i_host.start();
        send({TYPE_CODE, 1'b0, ~slaveAddress}, 1'b0);
        i_host.start();
        send({~TYPE_CODE, 1'b0, slaveAddress}, 1'b0);
        i_host.stop();
        foreach (badIns[j])
        begin
            i_host.start();
            send({TYPE_CODE, 1'b0, slaveAddress}, 1'b1);
            send(badIns[j], 1'b0);
            i_host.stop();
        end
        repeat (10) @(posedge ref_clk);
        cmd({OP_RD_WIPER, 4'h0}, 8'h00, 4, wip);
        finish_test();
    end
endmodule
